// ===== verilog/plw_defines.svh
// offsets, field positions, reset values and timing counts of the watchdog
`ifndef PLW_DEFINES_SVH
`define PLW_DEFINES_SVH

// ============================================================
// register addresses
`define PLW_MODE_ADDR 16'hFF48
`define PLW_KEY_ADDR 16'hFF49

// ============================================================
// register values
`define PLW_MODE_RESET 8'h67
`define PLW_MODE_FIXED 3'h3
`define PLW_KEY_READ 8'h9A
`define PLW_KEY_VALUE 8'hAC

// ============================================================
// field positions
`define PLW_STOP_BIT 4
`define PLW_SRC_BIT 3
`define PLW_OVF_MSB 2
`define PLW_FLAG_BIT 4

// ============================================================
// overflow exponents for select value zero
`define PLW_LS_EXP_BASE 5'h0B
`define PLW_FX_EXP_BASE 5'h0D

// ============================================================
// timing
`define PLW_CLK_FREQ_HZ 100000000
`define PLW_FX_FREQ_HZ 10000000
`define PLW_FX_DIV (`PLW_CLK_FREQ_HZ / `PLW_FX_FREQ_HZ)
`define PLW_RST_HOLD 8'h10

`endif

// ===== verilog/plw_pkg.sv
// types shared by the watchdog design files
package plw_pkg;

    // ============================================================
    // stored mode fields
    typedef struct packed {
        logic stop;
        logic src;
        logic [2:0] ovf;
    } plw_mode_s;

    // ============================================================
    // special function register access from the cpu
    typedef struct packed {
        logic wr;
        logic rd;
        logic bit_op;
        logic [15:0] addr;
        logic [7:0] wdata;
    } plw_bus_s;

    // ============================================================
    // power management and clock status
    typedef struct packed {
        logic halt;
        logic stop;
        logic osc_stab;
        logic fx_stopped;
        logic cpu_on_fx;
        logic ls_sw_stop;
    } plw_pm_s;

    // ============================================================
    // internal reset sequencer states
    typedef enum logic [1:0] {
        PLW_RUN = 2'b01,
        PLW_HOLD = 2'b10
    } plw_rst_e;

endpackage

// ===== verilog/plw_sync_edge.sv
// two-flop synchroniser with rising edge pulse for the low-speed oscillator
`timescale 1ns/100ps

module plw_sync_edge (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // asynchronous pin
    input wire logic pin,
    // one-cycle pulse per rising edge
    output logic rise
);

    logic meta;
    logic sync;
    logic sync_d;

    // ============================================================
    // synchroniser chain, meta read only by sync
    always_ff @(posedge clk) begin
        if (srst) begin
            meta <= 1'b0;
            sync <= 1'b0;
            sync_d <= 1'b0;
        end else begin
            meta <= pin;
            sync <= meta;
            sync_d <= sync;
        end
    end

    // ============================================================
    // registered edge pulse
    always_ff @(posedge clk) begin
        if (srst) begin
            rise <= 1'b0;
        end else begin
            rise <= sync & ~sync_d;
        end
    end

endmodule

// ===== verilog/plw_top.sv
// program loop watchdog: mode and key registers, counter, internal reset
`timescale 1ns/100ps
`include "plw_defines.svh"


module plw_top #(
    parameter int CNT_W = 21,
    parameter int FX_DIV = `PLW_FX_DIV,
    parameter logic [7:0] RST_HOLD = `PLW_RST_HOLD
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register access
    input wire plw_pkg::plw_bus_s bus,
    output logic [7:0] rdata,
    // clock sources and power state
    input wire logic lsosc_clk,
    input wire plw_pkg::plw_pm_s pm,
    input wire logic opt_ls_fixed,
    // reset cause and internal reset
    input wire logic flag_clr,
    output logic [7:0] reset_cause,
    output logic loop_reset
);

    localparam int DIV_W = $clog2(FX_DIV + 1);

    plw_pkg::plw_mode_s mode;
    plw_pkg::plw_rst_e state;
    plw_pkg::plw_rst_e next_state;
    logic mode_written;
    logic opt_fixed;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] lim_mask;
    logic [DIV_W-1:0] fx_cnt;
    logic [7:0] hold_cnt;
    logic [4:0] cur_exp;
    logic ls_rise;
    logic fx_tick;
    logic use_fx;
    logic fx_gate;
    logic ls_gate;
    logic tick;
    logic run;
    logic mode_wr;
    logic key_wr;
    logic kick;
    logic trip_mode;
    logic trip_key;
    logic overflow;
    logic trip;

    // ============================================================
    // decode helpers

    // address match of the access
    function automatic logic hit(input plw_pkg::plw_bus_s b,
                                 input logic [15:0] a);
        hit = b.addr == a;
    endfunction

    // overflow exponent for source and select field
    function automatic logic [4:0] limit_exp(input logic fx,
                                             input logic [2:0] ovf);
        limit_exp = (fx ? `PLW_FX_EXP_BASE : `PLW_LS_EXP_BASE) +
                    {2'h0, ovf};
    endfunction

    // ============================================================
    // access decode
    // byte writes and bit-operation accesses told apart by qualifier
    assign run = state == plw_pkg::PLW_RUN;
    assign mode_wr = run & bus.wr & ~bus.bit_op &
                     hit(bus, `PLW_MODE_ADDR);
    assign key_wr = run & bus.wr & hit(bus, `PLW_KEY_ADDR);
    assign kick = key_wr & ~bus.bit_op &
                  (bus.wdata == `PLW_KEY_VALUE);

    // illegal accesses, silenced once the watchdog has been stopped
    assign trip_mode = mode_wr & mode_written & ~mode.stop;
    assign trip_key = key_wr & ~mode.stop &
                      (bus.bit_op |
                       (bus.wdata != `PLW_KEY_VALUE));

    // ============================================================
    // option strap, caught while reset is held
    always_ff @(posedge clk) begin
        if (srst) begin
            opt_fixed <= opt_ls_fixed;
        end
    end

    // ============================================================
    // mode register, write once after reset
    always_ff @(posedge clk) begin
        if (srst || state == plw_pkg::PLW_HOLD) begin
            mode <= plw_pkg::plw_mode_s'(5'(`PLW_MODE_RESET));
            mode_written <= 1'b0;
        end else if (mode_wr && !mode_written) begin
            // fixed option forces low-speed source and no stop
            mode.stop <= opt_fixed ? 1'b0 :
                         bus.wdata[`PLW_STOP_BIT];
            mode.src <= opt_fixed ? 1'b0 :
                        bus.wdata[`PLW_SRC_BIT];
            mode.ovf <= bus.wdata[`PLW_OVF_MSB:0];
            mode_written <= 1'b1;
        end
    end

    // ============================================================
    // count sources
    // low-speed oscillator pin brought into the clk domain
    plw_sync_edge u_ls_sync (
        .clk(clk),
        .srst(srst),
        .pin(lsosc_clk),
        .rise(ls_rise)
    );

    // system clock enable from divider
    always_ff @(posedge clk) begin
        if (srst) begin
            fx_cnt <= '0;
            fx_tick <= 1'b0;
        end else if (fx_cnt == DIV_W'(FX_DIV - 1)) begin
            fx_cnt <= '0;
            fx_tick <= 1'b1;
        end else begin
            fx_cnt <= fx_cnt + 1'b1;
            fx_tick <= 1'b0;
        end
    end

    // source select and clock gating
    assign use_fx = mode.src & ~opt_fixed;
    assign fx_gate = pm.halt | pm.stop | pm.osc_stab |
                     pm.fx_stopped;
    assign ls_gate = ~opt_fixed & (pm.halt | pm.stop |
                     (pm.cpu_on_fx & pm.ls_sw_stop));
    assign tick = run & ~mode.stop &
                  (use_fx ? (fx_tick & ~fx_gate) :
                            (ls_rise & ~ls_gate));

    // ============================================================
    // overflow limit
    assign cur_exp = limit_exp(use_fx, mode.ovf);

    // mask of ones below the selected power of two
    genvar gi;
    for (gi = 0; gi < CNT_W; gi++) begin : g_mask
        assign lim_mask[gi] = 5'(gi) < cur_exp;
    end

    assign overflow = tick & (cnt == lim_mask);

    // ============================================================
    // watchdog counter
    // held, not cleared, while the source is gated
    always_ff @(posedge clk) begin
        if (srst || state == plw_pkg::PLW_HOLD) begin
            cnt <= '0;
        end else if (mode_wr || kick || trip) begin
            // any trip clears at once, so a hold never sees a stale count
            cnt <= '0;
        end else if (tick) begin
            cnt <= cnt + 1'b1;
        end
    end

    // ============================================================
    // internal reset sequencer
    assign trip = overflow | trip_mode | trip_key;

    // next state
    always_comb begin
        next_state = state;
        case (state)
            plw_pkg::PLW_RUN: begin
                if (trip) begin
                    next_state = plw_pkg::PLW_HOLD;
                end
            end
            plw_pkg::PLW_HOLD: begin
                if (hold_cnt == 8'h00) begin
                    next_state = plw_pkg::PLW_RUN;
                end
            end
            default: begin
                next_state = plw_pkg::PLW_RUN;
            end
        endcase
    end

    // state and hold length
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= plw_pkg::PLW_RUN;
            hold_cnt <= 8'h00;
        end else begin
            state <= next_state;
            if (state == plw_pkg::PLW_RUN) begin
                hold_cnt <= RST_HOLD - 8'h01;
            end else if (hold_cnt != 8'h00) begin
                hold_cnt <= hold_cnt - 8'h01;
            end
        end
    end

    // reset output straight from a flop
    always_ff @(posedge clk) begin
        if (srst) begin
            loop_reset <= 1'b0;
        end else begin
            loop_reset <= next_state == plw_pkg::PLW_HOLD;
        end
    end

    // ============================================================
    // reset cause flag, set wins over clear
    always_ff @(posedge clk) begin
        if (srst) begin
            reset_cause <= 8'h00;
        end else if (run && trip) begin
            reset_cause[`PLW_FLAG_BIT] <= 1'b1;
        end else if (flag_clr) begin
            reset_cause[`PLW_FLAG_BIT] <= 1'b0;
        end
    end

    // ============================================================
    // register read data
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            if (hit(bus, `PLW_MODE_ADDR)) begin
                rdata <= {`PLW_MODE_FIXED, mode};
            end else if (hit(bus, `PLW_KEY_ADDR)) begin
                rdata <= `PLW_KEY_READ;
            end else begin
                rdata <= 8'h00;
            end
        end
    end

    // ============================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_overflow;
        run && overflow;
    endsequence
    sequence s_held_reset;
        loop_reset [*2];
    endsequence

    property p_ovf_reset;
        s_overflow |=> s_held_reset;
    endproperty
    a_ovf_reset: assert property (p_ovf_reset)
        else $error("overflow did not raise internal reset");

    property p_flag;
        run && trip |=> reset_cause[`PLW_FLAG_BIT];
    endproperty
    a_flag: assert property (p_flag)
        else $error("reset cause flag not set");

    property p_ls_limit;
        s_overflow and !use_fx |-> cnt == CNT_W'((1 << (11 + mode.ovf)) - 1);
    endproperty
    a_ls_limit: assert property (p_ls_limit)
        else $error("low-speed overflow at wrong count");

    property p_fx_limit;
        s_overflow and use_fx |-> cnt == CNT_W'((1 << (13 + mode.ovf)) - 1);
    endproperty
    a_fx_limit: assert property (p_fx_limit)
        else $error("system clock overflow at wrong count");

    property p_stopped;
        mode.stop |=> $stable(cnt) || cnt == '0;
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("stopped watchdog still counting");

    property p_reset_mode;
        $fell(srst) |-> mode == 5'h07 && !mode_written;
    endproperty
    a_reset_mode: assert property (p_reset_mode)
        else $error("mode register reset value wrong");

    property p_second_write;
        mode_wr && mode_written && !mode.stop |=> s_held_reset;
    endproperty
    a_second_write: assert property (p_second_write)
        else $error("second mode write did not reset");

    property p_stop_silent;
        run && mode.stop && !overflow |=> !loop_reset;
    endproperty
    a_stop_silent: assert property (p_stop_silent)
        else $error("stopped watchdog raised internal reset");

    property p_fixed_src;
        opt_fixed |-> !mode.src && !mode.stop;
    endproperty
    a_fixed_src: assert property (p_fixed_src)
        else $error("fixed option allowed other source or stop");

    property p_kick;
        kick |=> cnt == '0 && !loop_reset;
    endproperty
    a_kick: assert property (p_kick)
        else $error("key write did not clear counter");

    property p_bad_key;
        key_wr && !mode.stop && bus.bit_op |=> ##1 loop_reset;
    endproperty
    a_bad_key: assert property (p_bad_key)
        else $error("bit access to key register did not reset");

    property p_key_read;
        bus.rd && hit(bus, `PLW_KEY_ADDR) |=> rdata == 8'h9A;
    endproperty
    a_key_read: assert property (p_key_read)
        else $error("key register read wrong value");

    property p_fx_gate;
        use_fx && fx_gate && !mode_wr && !kick |=> $stable(cnt);
    endproperty
    a_fx_gate: assert property (p_fx_gate)
        else $error("gated system clock source still counted");

    property p_mode_clear;
        mode_wr |=> cnt == '0;
    endproperty
    a_mode_clear: assert property (p_mode_clear)
        else $error("mode write did not clear counter");

endmodule

// ===== dv/test_program_loop_watchdog.sv
// self-checking testbench of the program loop watchdog
`timescale 1ns/100ps
`include "plw_defines.svh"

module test_program_loop_watchdog;

    // ============================================================
    // signals and design under test
    localparam logic [7:0] RH = 8'h04;
    localparam logic [15:0] MA = `PLW_MODE_ADDR;
    localparam logic [15:0] KA = `PLW_KEY_ADDR;
    logic clk;
    logic srst;
    logic lsosc_clk;
    logic opt_ls_fixed;
    logic flag_clr;
    logic loop_reset;
    logic [7:0] rdata;
    logic [7:0] reset_cause;
    plw_pkg::plw_bus_s bus;
    plw_pkg::plw_pm_s pm;
    int n_errors;
    int comparisons;

    // short fx divider and hold keep the run brief
    plw_top #(.CNT_W(21), .FX_DIV(1), .RST_HOLD(RH)) dut (
        .clk(clk),
        .srst(srst),
        .bus(bus),
        .rdata(rdata),
        .lsosc_clk(lsosc_clk),
        .pm(pm),
        .opt_ls_fixed(opt_ls_fixed),
        .flag_clr(flag_clr),
        .reset_cause(reset_cause),
        .loop_reset(loop_reset)
    );

    // ============================================================
    // clocks: 100 MHz system, low-speed oscillator of six cycles
    always #5 clk = ~clk;
    always #30 lsosc_clk = ~lsosc_clk;

    // ============================================================
    // shared tasks
    // all drivers act one nanosecond after the rising edge
    task automatic step(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_in(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic bus_wr(input logic [15:0] a, input logic [7:0] d,
                          input logic b);
        bus.wr = 1'b1;
        bus.bit_op = b;
        bus.addr = a;
        bus.wdata = d;
        step(1);
        bus.wr = 1'b0;
        bus.bit_op = 1'b0;
    endtask

    task automatic bus_rd(input logic [15:0] a, input logic [7:0] exp);
        bus.rd = 1'b1;
        bus.addr = a;
        step(1);
        bus.rd = 1'b0;
        chk8(rdata, exp);
        // one idle edge before the next strobe may rise
        step(1);
    endtask

    // wait for the internal reset inside a window, then check its pulse
    task automatic wait_rst(input int lo, input int hi);
        int n;
        int h;
        n = 0;
        h = 0;
        while (loop_reset !== 1'b1 && n < hi + 20) begin
            step(1);
            n++;
        end
        chk_in(n, lo, hi);
        chk8(reset_cause, 8'h10);
        while (loop_reset === 1'b1 && h < 50) begin
            step(1);
            h++;
        end
        chk_in(h, int'(RH), int'(RH));
        flag_clr = 1'b1;
        step(1);
        flag_clr = 1'b0;
        chk8(reset_cause, 8'h00);
    endtask

    // no internal reset may appear for n cycles
    task automatic quiet(input int n);
        repeat (n) begin
            step(1);
            chk8({7'h00, loop_reset}, 8'h00);
        end
    endtask

    task automatic do_reset(input logic opt);
        srst = 1'b1;
        opt_ls_fixed = opt;
        step(12);
        srst = 1'b0;
    endtask

    // ============================================================
    // scenarios
    // reset values, key read-back, unmapped read, good key
    task automatic t_regs();
        do_reset(1'b0);
        chk8(reset_cause, 8'h00);
        bus_rd(MA, 8'h67);
        bus_rd(KA, 8'h9A);
        bus_rd(16'hFF4A, 8'h00);
        bus_wr(KA, 8'hAC, 1'b0);
        bus_rd(KA, 8'h9A);
        quiet(5);
    endtask

    // wrong key value and single-bit key access trip at once
    task automatic t_key_bad();
        bus_wr(KA, 8'h00, 1'b0);
        wait_rst(0, 2);
        bus_wr(KA, 8'hAC, 1'b1);
        wait_rst(0, 2);
    endtask

    // mode register is written once; a second write trips
    task automatic t_mode_twice();
        bus_wr(MA, 8'h68, 1'b0);
        bus_rd(MA, 8'h68);
        bus_wr(MA, 8'h68, 1'b0);
        wait_rst(0, 2);
    endtask

    // a stopped watchdog forgives every illegal access
    task automatic t_stopped();
        bus_wr(MA, 8'h70, 1'b0);
        step(1);
        bus_wr(MA, 8'h60, 1'b0);
        step(1);
        bus_wr(KA, 8'h00, 1'b0);
        step(1);
        bus_wr(KA, 8'hAC, 1'b1);
        quiet(40);
        bus_rd(MA, 8'h70);
        do_reset(1'b0);
    endtask

    // system clock: halt gating, held count, key restart, doubling
    task automatic t_fx();
        bus_wr(MA, 8'h68, 1'b0);
        step(3000);
        pm.halt = 1'b1;
        step(1000);
        pm.halt = 1'b0;
        pm.osc_stab = 1'b1;
        step(500);
        pm.osc_stab = 1'b0;
        pm.fx_stopped = 1'b1;
        step(500);
        pm.fx_stopped = 1'b0;
        wait_rst(8192 - 3000 - 10, 8192 - 3000 + 10);
        bus_wr(MA, 8'h68, 1'b0);
        step(4000);
        bus_wr(KA, 8'hAC, 1'b0);
        wait_rst(8192 - 10, 8192 + 10);
        bus_wr(MA, 8'h69, 1'b0);
        wait_rst(16384 - 10, 16384 + 10);
    endtask

    // low-speed clock: 2^11 ticks of six cycles, stop gating
    task automatic t_ls();
        bus_wr(MA, 8'h60, 1'b0);
        step(6000);
        pm.stop = 1'b1;
        step(600);
        pm.stop = 1'b0;
        pm.cpu_on_fx = 1'b1;
        pm.ls_sw_stop = 1'b1;
        step(600);
        pm.cpu_on_fx = 1'b0;
        pm.ls_sw_stop = 1'b0;
        wait_rst(12288 - 6000 - 20, 12288 - 6000 + 20);
    endtask

    // fixed oscillator option: source and stop bits are ignored
    task automatic t_fixed();
        do_reset(1'b1);
        bus_wr(MA, 8'h68, 1'b0);
        wait_rst(12288 - 20, 12288 + 20);
        bus_wr(MA, 8'h70, 1'b0);
        wait_rst(12288 - 20, 12288 + 20);
    endtask

    // ============================================================
    // verdict and end of run
    task automatic test_done();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog of the run itself
    initial begin
        #950000;
        n_errors++;
        test_done();
    end

    // main sequence
    initial begin
        clk = 1'b0;
        lsosc_clk = 1'b0;
        srst = 1'b1;
        opt_ls_fixed = 1'b0;
        flag_clr = 1'b0;
        bus = '0;
        pm = '0;
        n_errors = 0;
        comparisons = 0;
        #1;
        t_regs();
        t_key_bad();
        t_mode_twice();
        t_stopped();
        t_fx();
        t_ls();
        t_fixed();
        test_done();
    end

endmodule
